// >>> core/slr_link_regs.sv
`timescale 1ns/100ps
`include "slr_consts.svh"
module slr_link_regs (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Register access
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire slr_pkg::slr_ofs_t  reg_addr,
  input  wire slr_pkg::slr_byte_t reg_wdata,
  output logic [7:0]            reg_rdata,
  // Link receiver events
  input  wire logic             sync_mismatch_evt,
  input  wire logic             invalid_cmd_evt,
  input  wire logic             link_irq_evt,
  input  wire slr_pkg::slr_byte_t err_lower_in,
  output logic                  error_flags_clear,
  output logic                  link_irq,
  // Programming
  input  wire logic             program_timer_disable,
  input  wire logic             otp_timer_busy,
  output logic                  program_req,
  output logic                  program_active,
  output logic [10:0]           otp_write_address,
  output logic [31:0]           otp_write_data
);
  import slr_pkg::*;

  typedef struct packed {
    logic      sync_flag;
    logic      cmd_flag;
    logic      irq_pend;
    logic      irq_en;
    slr_word_t data;
    slr_byte_t addr_lo;
    logic [2:0] addr_hi;
    logic      start;
    slr_byte_t rdata;
  } slr_reg_state_t;

  slr_reg_state_t s_r;
  slr_reg_state_t s_nxt;
  slr_prog_if     pif ();

  function automatic logic hit(input slr_ofs_t a, input slr_ofs_t o);
    hit = reg_wr && (a == o);
  endfunction : hit

  logic clr;

  // ========================================================================
  // Programming sequencer
  slr_prog_ctrl u_prog (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pif     (pif)
  );
  assign pif.start     = s_r.start;
  assign pif.timer_dis = program_timer_disable;
  assign pif.otp_busy  = otp_timer_busy;

  // ========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    clr   = hit(reg_addr, `SLR_OFS_ERR_HI)
            && reg_wdata[`SLR_BIT_CLR];
    // A set in the same cycle as a clear wins, so an error that lands
    // on the clear write is kept and does not go unseen.
    if (clr) begin
      s_nxt.sync_flag = 1'b0;
      s_nxt.cmd_flag  = 1'b0;
    end
    if (sync_mismatch_evt) begin
      s_nxt.sync_flag = 1'b1;
    end
    if (invalid_cmd_evt) begin
      s_nxt.cmd_flag = 1'b1;
    end
    if (hit(reg_addr, `SLR_OFS_IRQ) && reg_wdata[`SLR_BIT_IRQ]) begin
      s_nxt.irq_pend = 1'b0;
    end
    if (link_irq_evt) begin
      s_nxt.irq_pend = 1'b1;
    end
    if (hit(reg_addr, `SLR_OFS_IRQ_EN)) begin
      s_nxt.irq_en = reg_wdata[`SLR_BIT_IRQ];
    end
    if (hit(reg_addr, `SLR_OFS_DATA0)) s_nxt.data[7:0]   = reg_wdata;
    if (hit(reg_addr, `SLR_OFS_DATA1)) s_nxt.data[15:8]  = reg_wdata;
    if (hit(reg_addr, `SLR_OFS_DATA2)) s_nxt.data[23:16] = reg_wdata;
    if (hit(reg_addr, `SLR_OFS_DATA3)) s_nxt.data[31:24] = reg_wdata;
    if (hit(reg_addr, `SLR_OFS_ADDR_LO)) begin
      s_nxt.addr_lo = reg_wdata;
    end
    if (pif.begin_p) begin
      s_nxt.start = 1'b0;
    end
    if (hit(reg_addr, `SLR_OFS_ADDR_HI)) begin
      s_nxt.addr_hi = reg_wdata[2:0];
      s_nxt.start   = reg_wdata[`SLR_BIT_START];
    end
    s_nxt.rdata = `SLR_ZERO_BYTE;
    if (reg_rd) begin
      case (reg_addr)
        `SLR_OFS_ERR_HI:  s_nxt.rdata = {6'h00, s_r.cmd_flag,
                                         s_r.sync_flag};
        `SLR_OFS_IRQ:     s_nxt.rdata = {7'h00, s_r.irq_pend};
        `SLR_OFS_IRQ_EN:  s_nxt.rdata = {7'h00, s_r.irq_en};
        `SLR_OFS_DATA0:   s_nxt.rdata = s_r.data[7:0];
        `SLR_OFS_DATA1:   s_nxt.rdata = s_r.data[15:8];
        `SLR_OFS_DATA2:   s_nxt.rdata = s_r.data[23:16];
        `SLR_OFS_DATA3:   s_nxt.rdata = s_r.data[31:24];
        `SLR_OFS_ADDR_LO: s_nxt.rdata = s_r.addr_lo;
        `SLR_OFS_ADDR_HI: s_nxt.rdata = {s_r.start, 4'h0, s_r.addr_hi};
        default:          s_nxt.rdata = `SLR_ZERO_BYTE;
      endcase
    end
  end

  // ========================================================================
  // Outputs
  assign reg_rdata         = s_r.rdata;
  assign error_flags_clear = clr;
  assign link_irq          = s_r.irq_pend && s_r.irq_en;
  assign program_req       = pif.req;
  assign program_active    = pif.active;
  assign otp_write_address = {s_r.addr_hi, s_r.addr_lo};
  assign otp_write_data    = s_r.data;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : slr_link_regs

// >>> core/slr_consts.svh
`ifndef SLR_CONSTS_SVH
`define SLR_CONSTS_SVH

// ==========================================================================
// Register offsets
`define SLR_OFS_ERR_LO   6'h08
`define SLR_OFS_ERR_HI   6'h09
`define SLR_OFS_IRQ      6'h0a
`define SLR_OFS_IRQ_EN   6'h0b
`define SLR_OFS_DATA0    6'h10
`define SLR_OFS_DATA1    6'h11
`define SLR_OFS_DATA2    6'h12
`define SLR_OFS_DATA3    6'h13
`define SLR_OFS_ADDR_LO  6'h14
`define SLR_OFS_ADDR_HI  6'h15

// ==========================================================================
// Field positions and reset values
`define SLR_BIT_SYNC     0
`define SLR_BIT_CMD      1
`define SLR_BIT_CLR      7
`define SLR_BIT_IRQ      0
`define SLR_BIT_START    7
`define SLR_BYTE_RST     8'h00
`define SLR_ZERO_BYTE    8'h00

`endif

// >>> core/slr_pkg.sv
package slr_pkg;
  typedef logic [5:0]  slr_ofs_t;
  typedef logic [7:0]  slr_byte_t;
  typedef logic [10:0] slr_addr_t;
  typedef logic [31:0] slr_word_t;
  typedef enum logic [2:0] {
    SLR_IDLE = 3'b001,
    SLR_BUSY = 3'b010,
    SLR_HOLD = 3'b100
  } slr_pst_t;
endpackage : slr_pkg

// >>> core/slr_prog_if.sv
`timescale 1ns/100ps
interface slr_prog_if;
  import slr_pkg::*;
  logic      start;
  logic      timer_dis;
  logic      otp_busy;
  logic      begin_p;
  logic      active;
  logic      req;
  modport ctrl (input start, timer_dis, otp_busy,
                output begin_p, active, req);
  modport regs (output start, timer_dis, otp_busy,
                input begin_p, active, req);
endinterface : slr_prog_if

// >>> core/slr_prog_ctrl.sv
`timescale 1ns/100ps
`include "slr_consts.svh"
module slr_prog_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register side
  slr_prog_if.ctrl pif
);
  import slr_pkg::*;

  typedef struct packed {
    slr_pst_t st;
  } slr_pc_state_t;

  slr_pc_state_t s_r;
  slr_pc_state_t s_nxt;

  // ========================================================================
  // Sequencing
  // Timed mode pulses the request once; the external timer then reports
  // busy. Untimed mode follows the start bit level one cycle late, through the HOLD state.
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      SLR_IDLE: begin
        if (pif.start && !pif.timer_dis) begin
          s_nxt.st = SLR_BUSY;
        end else if (pif.start) begin
          s_nxt.st = SLR_HOLD;
        end
      end
      SLR_BUSY: begin
        if (!pif.otp_busy) begin
          s_nxt.st = SLR_IDLE;
        end
      end
      SLR_HOLD: begin
        if (!pif.start) begin
          s_nxt.st = SLR_IDLE;
        end
      end
      default: s_nxt.st = SLR_IDLE;
    endcase
  end

  // Begin pulse clears the start bit in timed mode.
  assign pif.begin_p = (s_r.st == SLR_IDLE) && pif.start
                       && !pif.timer_dis;
  assign pif.active  = (s_r.st == SLR_BUSY);
  assign pif.req     = pif.begin_p || (s_r.st == SLR_HOLD);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r.st <= SLR_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : slr_prog_ctrl

// >>> verification/slr_link_regs_asserts.sv
`timescale 1ns/100ps
// ====================================
// Port checker for the register bank.
module slr_chk (
  // Clock, reset and bus
  input wire logic               sys_clk,
  input wire logic               resetn,
  input wire logic               reg_wr,
  input wire slr_pkg::slr_ofs_t  reg_addr,
  input wire slr_pkg::slr_byte_t reg_wdata,
  // Interrupt and programming
  input wire logic               link_irq_evt,
  input wire logic               error_flags_clear,
  input wire logic               link_irq,
  input wire logic               program_timer_disable,
  input wire logic               otp_timer_busy,
  input wire logic               program_req,
  input wire logic               program_active,
  input wire logic [10:0]        otp_write_address,
  input wire logic [31:0]        otp_write_data
);
  import slr_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire w9  = reg_wr && reg_addr == 6'h09;
  wire w15 = reg_wr && reg_addr == 6'h15;
  chk_clr_pulse: assert property (
    error_flags_clear == (w9 && reg_wdata[7])) else $error("bad clear");
  chk_irq_clear: assert property (
    reg_wr && reg_addr == 6'h0a && reg_wdata[0] && !link_irq_evt |=>
    !link_irq) else $error("irq not cleared");
  chk_irq_off: assert property (
    reg_wr && reg_addr == 6'h0b && !reg_wdata[0] |=> !link_irq)
    else $error("irq while disabled");
  chk_irq_hold: assert property (
    link_irq && !reg_wr |=> link_irq) else $error("irq dropped");
  chk_data_lsb: assert property (
    reg_wr && reg_addr == 6'h10 |=> otp_write_data[7:0] == $past(reg_wdata))
    else $error("data byte wrong");
  chk_addr_high: assert property (
    w15 |=> otp_write_address[10:8] == $past(reg_wdata[2:0]))
    else $error("address high wrong");
  chk_timed_pulse: assert property (
    program_req && !program_timer_disable |=> !program_req && program_active)
    else $error("timed start wrong");
  chk_hold_level: assert property (
    program_req && program_timer_disable && !$past(w15) |=> program_req)
    else $error("start not held");
  chk_active_end: assert property (
    program_active && $past(program_active) && !otp_timer_busy |=>
    !program_active) else $error("active stuck");
  cover property (link_irq);
  cover property (program_active);
  cover property (program_req && program_timer_disable);
  cover property (error_flags_clear);
endmodule : slr_chk
bind slr_link_regs slr_chk chk_u (.sys_clk, .resetn, .reg_wr, .reg_addr,
  .reg_wdata, .link_irq_evt, .error_flags_clear, .link_irq,
  .program_timer_disable, .otp_timer_busy, .program_req, .program_active,
  .otp_write_address, .otp_write_data);

// >>> verification/testbench.sv
`timescale 1ns/100ps
// ====================================
// Bench with a reference map kept in an int array.
module testbench;
  import slr_pkg::*;
  logic       sys_clk, resetn, reg_wr, reg_rd, sev, cev, iev, tdis, busy;
  logic       clr, irq, req, act;
  slr_ofs_t   reg_addr;
  slr_byte_t  reg_wdata;
  logic [7:0] reg_rdata;
  logic [10:0] oa;
  logic [31:0] od;
  int         m[64];
  int         failures, num_checks, seed, i;
  slr_link_regs dut_u (.sys_clk, .resetn, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .sync_mismatch_evt(sev), .invalid_cmd_evt(cev),
    .link_irq_evt(iev), .err_lower_in(8'h00), .error_flags_clear(clr),
    .link_irq(irq), .program_timer_disable(tdis), .otp_timer_busy(busy),
    .program_req(req), .program_active(act), .otp_write_address(oa),
    .otp_write_data(od));
  task chk(input logic [31:0] g, input int e);
    num_checks++;
    if (g !== 32'(e)) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input int a, input int d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= 6'(a);
    reg_wdata <= 8'(d);
    case (a)
      'h09: if (d[7]) m[9] = 0;
      'h0a: if (d[0]) m[10] = 0;
      'h0b: m[11] = d & 1;
      'h15: m[21] = d & 'h87;
      default: m[a] = d & 'hff;
    endcase
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(negedge sys_clk);
  endtask : wr
  task rd(input int a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= 6'(a);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata & (a == 9 ? 8'h03 : 8'hff), m[a]);
  endtask : rd
  // Bit 0 pulses sync, bit 1 command, bit 2 interrupt.
  task ev(input int k);
    @(posedge sys_clk);
    sev <= k[0];
    cev <= k[1];
    iev <= k[2];
    m[9] |= k & 3;
    if (k[2]) m[10] = 1;
    @(posedge sys_clk);
    {sev, cev, iev} <= 3'h0;
    @(negedge sys_clk);
  endtask : ev
  task done(input string s);
    $display("test %s finished", s);
  endtask : done
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    {resetn, reg_wr, reg_rd, sev, cev, iev, tdis, busy} = 8'h00;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    seed = 32'h667a_9ce2;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    for (i = 8; i < 'h17; i++) rd(i);
    done("reset");
    for (i = 'h10; i < 'h15; i++) wr(i, $random(seed));
    wr('h15, $random(seed) & 'h07);
    chk(od, m[16] | m[17] << 8 | m[18] << 16 | m[19] << 24);
    chk(oa, m[20] | m[21] << 8);
    for (i = 'h10; i < 'h16; i++) rd(i);
    done("staging");
    ev(1);
    rd(9);
    wr(9, 'h7f);
    rd(9);
    ev(2);
    rd(9);
    wr(9, 'h80);
    rd(9);
    done("errors");
    ev(4);
    rd('h0a);
    chk(irq, 0);
    wr('h0b, 1);
    chk(irq, 1);
    rd('h0b);
    wr('h0a, 0);
    rd('h0a);
    wr('h0a, 1);
    rd('h0a);
    ev(4);
    wr('h0b, 0);
    chk(irq, 0);
    done("interrupt");
    @(posedge sys_clk);
    busy <= 1'b1;
    wr('h15, 'h81);
    chk(req, 1);
    @(negedge sys_clk);
    chk(req, 0);
    chk(act, 1);
    m[21] &= 'h07;
    rd('h15);
    @(posedge sys_clk);
    busy <= 1'b0;
    for (i = 0; i < 10 && act; i++) @(negedge sys_clk);
    chk(act, 0);
    @(posedge sys_clk);
    tdis <= 1'b1;
    wr('h15, 'h82);
    repeat (4) @(negedge sys_clk);
    chk(req, 1);
    rd('h15);
    wr('h15, 'h02);
    // The untimed request trails the start bit by one cycle.
    @(negedge sys_clk);
    chk(req, 0);
    done("program");
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    for (i = 0; i < 64; i++) m[i] = 0;
    for (i = 8; i < 'h17; i++) rd(i);
    chk(irq, 0);
    chk(req, 0);
    done("reset again");
    results();
  end
endmodule : testbench
